/* logic/charger_power_path_defs.vh */
`ifndef CHARGER_POWER_PATH_DEFS_VH
`define CHARGER_POWER_PATH_DEFS_VH

// clocks
`define SYS_CLK_HZ          25000000
`define TICK_HZ             125000
`define TICK_DIV            (`SYS_CLK_HZ / `TICK_HZ)
`define TICK_CNT_W          8

// input qualification (immunity) time, in microseconds and in ticks
`define QUAL_TIME_US        200
`define QUAL_TICKS          ((`QUAL_TIME_US * `TICK_HZ + 999999) / 1000000)
`define QUAL_CNT_W          6

// watchdog periods: seconds for the documented setting, ticks derived
`define WDT_163_S           163
`define WDT_163_TICKS       (`WDT_163_S * `TICK_HZ)
`define WDT_CNT_W           25

// register bus
`define ADDR_W              4
`define DATA_W              8
`define ADDR_CTRL           4'h0
`define ADDR_STATUS         4'h1

// control register fields
`define CTRL_HIZ            0
`define CTRL_INHIBIT        1
`define CTRL_TREG_LO        2
`define CTRL_TREG_HI        3
`define CTRL_WDT_LO         4
`define CTRL_WDT_HI         5
`define CTRL_RESET          8'h0c

// watchdog period field codes
`define WDT_OFF             2'b00
`define WDT_SEL_1           2'b01
`define WDT_SEL_2           2'b10
`define WDT_SEL_163         2'b11

// status register fields
`define STAT_PASS           0
`define STAT_CHG_EN         1
`define STAT_BATT_ON        2
`define STAT_SUPPLEMENT     3
`define STAT_CHG_REDUCE     4
`define STAT_SYS_REG        5
`define STAT_WDT_EXPIRED    6
`define STAT_QUALIFYING     7

`endif

/* logic/power_path_tick.v */
`timescale 1ns/1ps
`default_nettype none

`include "charger_power_path_defs.vh"

// divides the system clock down to the internal 125 kHz tick
module power_path_tick #(
    parameter [`TICK_CNT_W-1:0] DIV = `TICK_DIV
) (
    // clock and reset
    input  wire clk_sys,
    input  wire reset_n,
    // tick out
    output reg  tick
);

    reg [`TICK_CNT_W-1:0] count;   // cycles since last tick

    // free running divider, one-cycle pulse every DIV cycles
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count <= {`TICK_CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (count == DIV - 1'b1) begin
            count <= {`TICK_CNT_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule // power_path_tick

`default_nettype wire

/* logic/charger_power_path_control.v */
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none


// register map, 8-bit registers on a 4-bit address
//   0x0 control, read/write
//     bit 0    input path off, holds the pass switch open
//     bit 1    charge inhibit, battery charge path only
//     [3:2]    die temperature threshold select, 11 by default
//     [5:4]    watchdog period, 00 keeps the watchdog off
//     [7:6]    read as zero, writes ignored
//   0x1 status, read only
//     [5:0]    the six switch and loop outputs, in port order
//     bit 6    watchdog expired, sticky, cleared by reading status
//     bit 7    input qualification in progress
//   other addresses read as zero and drop their writes
//
// comparator inputs pass two flops of synchronisation and the switch
// outputs add one more, so an input change shows three edges later
//
// timing runs on a 125 kHz tick divided down from the system clock;
// qualification needs 25 ticks of unbroken good input, so the real
// wait lies between 24 and 25 tick periods, set by the tick phase
//
// limitations: the analog loops, the charge profile and battery
// temperature sensing live outside; this block only decides which
// switches may close and which loops must act, and it raises no
// interrupt, so software polls the status register

`include "charger_power_path_defs.vh"

module charger_power_path_control #(
    // watchdog lengths in ticks for the three enabled settings
    parameter [`WDT_CNT_W-1:0] WDT_TICKS_1   = 25'd5000000,
    parameter [`WDT_CNT_W-1:0] WDT_TICKS_2   = 25'd10000000,
    parameter [`WDT_CNT_W-1:0] WDT_TICKS_163 = `WDT_163_TICKS
) (
    // clock and reset
    input  wire               clk_sys,
    input  wire               reset_n,
    // register port
    input  wire [`ADDR_W-1:0] reg_addr,
    input  wire [`DATA_W-1:0] reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output reg  [`DATA_W-1:0] reg_rdata,
    // supply comparators
    input  wire               in_above_uvlo,
    input  wire               batt_above_uvlo,
    input  wire               in_good,
    input  wire               in_fault,
    input  wire               in_above_target,
    input  wire               input_limited,
    input  wire               sys_below_batt,
    input  wire [3:0]         die_over_thresh,
    // switch and loop controls
    output reg                input_pass_switch,
    output reg                batt_charge_en,
    output reg                batt_switch_full_on,
    output reg                supplement_mode,
    output reg                charge_reduce,
    output reg                sys_regulate
);

    // one-hot codes keep each state a single flop; a stray code
    // lands in the default branch and falls back to off
    // qualification state machine, one-hot
    localparam [2:0] ST_OFF  = 3'b001;  // no good source
    localparam [2:0] ST_QUAL = 3'b010;  // immunity timer running
    localparam [2:0] ST_ON   = 3'b100;  // system path started

    // internal tick
    wire tick;                          // one pulse per 125 kHz period

    // synchronisers: first stage feeds only the second
    reg  [5:0] sync_a;                  // first stage
    reg  [5:0] sync_b;                  // second stage, used by logic
    wire       s_supply_ok;             // either supply above lockout
    wire       s_in_good;               // input recognised as good source
    wire       s_in_fault;              // input out of range
    wire       s_above_target;          // input above system target
    wire       s_limited;               // input current or voltage limited
    wire       s_sys_below_batt;        // system rail fell below battery
    reg  [3:0] temp_a;                  // die comparators, first stage
    reg  [3:0] temp_b;                  // die comparators, second stage

    // control state
    reg  [2:0]             state;       // qualification state
    reg  [2:0]             next_state;  // next qualification state
    reg  [`QUAL_CNT_W-1:0] qual_cnt;    // ticks spent qualifying
    reg  [`DATA_W-1:0]     ctrl;        // control register
    reg                    supply_q;    // supply_ok one cycle ago
    reg  [`WDT_CNT_W-1:0]  wdt_cnt;     // watchdog ticks elapsed
    reg                    wdt_expired; // sticky expiry flag
    reg  [`WDT_CNT_W-1:0]  wdt_limit;   // selected watchdog length
    wire                   regs_reset;  // hold registers at default
    wire                   wdt_fire;    // watchdog reached its limit
    wire                   stat_rd;     // status read this cycle
    wire                   ctrl_wr;     // control write this cycle
    wire                   thermal_hot; // die above selected threshold
    wire [`DATA_W-1:0]     status;      // live status word

    // the divider count is narrower than the 32-bit integer but holds the
    // ratio of 200, so cutting it to the counter width loses nothing
    localparam [31:0]            TICK_DIV_FULL = `TICK_DIV;
    localparam [`TICK_CNT_W-1:0] TICK_DIV_CUT  = TICK_DIV_FULL[`TICK_CNT_W-1:0];

    // the 125 kHz tick generator; one divider serves every timer here
    power_path_tick #(
        .DIV (TICK_DIV_CUT)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (tick)
    );

    // the comparators follow the analog supplies and know nothing of
    // this clock; two flops per line keep metastability out of the
    // state machine at the price of two cycles of latency
    // two flip-flop synchronisers for every comparator
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
            temp_a <= 4'h0;
            temp_b <= 4'h0;
        end else begin
            sync_a <= {sys_below_batt, input_limited, in_above_target,
                       in_fault, in_good, in_above_uvlo | batt_above_uvlo};
            sync_b <= sync_a;
            temp_a <= die_over_thresh;
            temp_b <= temp_a;
        end
    end

    assign s_supply_ok      = sync_b[0];
    assign s_in_good        = sync_b[1];
    assign s_in_fault       = sync_b[2];
    assign s_above_target   = sync_b[3];
    assign s_limited        = sync_b[4];
    assign s_sys_below_batt = sync_b[5];

    // registers stay at default while both supplies are below lockout
    // and are reset again on the rising edge of supply_ok
    assign regs_reset = !s_supply_ok || !supply_q;

    // remembers the synchronised supply flag so that its rise can be
    // seen; the registers are held one extra cycle on that rise
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            supply_q <= 1'b0;
        end else begin
            supply_q <= s_supply_ok;
        end
    end

    // a fault or a lost input always wins over the timer, so the
    // system path never starts on a source that went bad mid-count
    // qualification next state
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                // wait for a good input that is also in range
                if (s_in_good && !s_in_fault) begin
                    next_state = ST_QUAL;
                end
            end
            ST_QUAL: begin
                // any drop sends the count back to the start
                if (!s_in_good || s_in_fault) begin
                    next_state = ST_OFF;
                end else if (tick && qual_cnt == `QUAL_TICKS - 1) begin
                    next_state = ST_ON;      // still good at expiry
                end
            end
            ST_ON: begin
                // leave at once when the input fails or goes out of range
                if (!s_in_good || s_in_fault) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                // unreachable codes recover to the safe state
                next_state = ST_OFF;
            end
        endcase
    end

    // the counter is cleared on every entry to qualifying, so a source
    // that bounces never inherits ticks from an earlier attempt
    // qualification state and tick counter
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state    <= ST_OFF;
            qual_cnt <= {`QUAL_CNT_W{1'b0}};
        end else begin
            state <= next_state;
            // counter restarts whenever qualifying is left or entered anew
            if (next_state != ST_QUAL || state != ST_QUAL) begin
                qual_cnt <= {`QUAL_CNT_W{1'b0}};
            end else if (tick) begin
                qual_cnt <= qual_cnt + 1'b1;
            end
        end
    end

    // code 00 gives a zero limit, which the watchdog reads as off
    // watchdog length chosen by the period field
    always @* begin
        case (ctrl[`CTRL_WDT_HI:`CTRL_WDT_LO])
            `WDT_SEL_1:   wdt_limit = WDT_TICKS_1;
            `WDT_SEL_2:   wdt_limit = WDT_TICKS_2;
            `WDT_SEL_163: wdt_limit = WDT_TICKS_163;
            default:      wdt_limit = {`WDT_CNT_W{1'b0}};
        endcase
    end

    // bus decodes; the watchdog fires on the tick that ends its count
    assign ctrl_wr  = reg_wr && reg_addr == `ADDR_CTRL;
    assign stat_rd  = reg_rd && reg_addr == `ADDR_STATUS;
    assign wdt_fire = tick && wdt_limit != {`WDT_CNT_W{1'b0}}
                      && wdt_cnt == wdt_limit - 1'b1;

    // watchdog: any control write restarts it; expiry restores the
    // control defaults so a host that has hung cannot hold hi-z forever
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wdt_cnt <= {`WDT_CNT_W{1'b0}};
        end else if (regs_reset || ctrl_wr || wdt_fire ||
                     wdt_limit == {`WDT_CNT_W{1'b0}}) begin
            wdt_cnt <= {`WDT_CNT_W{1'b0}};
        end else if (tick) begin
            // counts whole ticks, so the period is exact to one tick
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end

    // a write landing in the expiry cycle cannot cancel the expiry, which
    // is what lets the watchdog win back a hung configuration
    // control register; watchdog expiry overrides a same-cycle write
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `CTRL_RESET;
        end else if (regs_reset || wdt_fire) begin
            ctrl <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            // unused high bits stay zero
            ctrl <= {2'b00, reg_wdata[5:0]};
        end
    end

    // the flag stays until software has seen it or both supplies drop below lockout
    // sticky expiry flag, cleared by reading status; a new expiry wins
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wdt_expired <= 1'b0;
        end else if (regs_reset) begin
            wdt_expired <= 1'b0;
        end else if (wdt_fire) begin
            wdt_expired <= 1'b1;
        end else if (stat_rd) begin
            wdt_expired <= 1'b0;
        end
    end

    // index 3 is the hottest comparator and the default selection
    // die temperature against the selected regulation threshold
    assign thermal_hot = temp_b[ctrl[`CTRL_TREG_HI:`CTRL_TREG_LO]];

    // every output is a flop, so the analog side never sees a glitch
    // from the decode; the cost is one more cycle of latency
    // switch and loop outputs, all registered
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            input_pass_switch   <= 1'b0;
            batt_charge_en      <= 1'b0;
            batt_switch_full_on <= 1'b0;
            supplement_mode     <= 1'b0;
            charge_reduce       <= 1'b0;
            sys_regulate        <= 1'b0;
        end else begin
            // pass switch needs a qualified, in-range input and no hi-z;
            // a fault removes it without waiting on the state machine
            input_pass_switch <= state == ST_ON && !s_in_fault
                                 && s_in_good
                                 && !ctrl[`CTRL_HIZ];
            // charging only through a live input path and without inhibit
            batt_charge_en    <= state == ST_ON && !s_in_fault && s_in_good
                                 && !ctrl[`CTRL_HIZ]
                                 && !ctrl[`CTRL_INHIBIT]
                                 && !s_sys_below_batt;
            // supplement when the input is qualified (ST_ON), even in hi-z, but cannot hold the rail
            supplement_mode   <= state == ST_ON && s_sys_below_batt;
            // discharge path ignores inhibit: full on in hi-z, when the
            // input is gone or the battery must help the load
            batt_switch_full_on <= state != ST_ON || s_in_fault || !s_in_good
                                   || ctrl[`CTRL_HIZ]
                                   || s_sys_below_batt;
            // charge current yields to heat and to the system load
            charge_reduce     <= thermal_hot || s_limited;
            // regulation to target only with enough headroom on the input
            sys_regulate      <= s_above_target;
        end
    end

    // built from the output flops, so status matches the pins
    // live status word
    assign status = {state == ST_QUAL, wdt_expired, sys_regulate, charge_reduce,
                     supplement_mode, batt_switch_full_on, batt_charge_en,
                     input_pass_switch};

    // zero between reads keeps stale data off the bus
    // read data in the cycle after the read strobe; unmapped reads zero
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= {`DATA_W{1'b0}};
        end else if (reg_rd && reg_addr == `ADDR_CTRL) begin
            reg_rdata <= ctrl;
        end else if (stat_rd) begin
            reg_rdata <= status;
        end else begin
            reg_rdata <= {`DATA_W{1'b0}};
        end
    end

endmodule // charger_power_path_control

`default_nettype wire

/* dv/charger_power_path_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charger_power_path_defs.vh"
// watches the control block from its ports only
module charger_power_path_checker (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               reset_n,
    // register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [`DATA_W-1:0] reg_rdata,
    // comparators
    input wire logic               in_good,
    input wire logic               in_fault,
    input wire logic               in_above_target,
    // switch controls
    input wire logic               input_pass_switch,
    input wire logic               batt_charge_en,
    input wire logic               batt_switch_full_on,
    input wire logic               supplement_mode,
    input wire logic               sys_regulate
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // shortest legal wait: tick phase may shave one tick
    localparam int QUAL_MIN = (`QUAL_TICKS - 1) * `TICK_DIV;
    logic [15:0] good_run; // unbroken good-input cycles, saturating
    // restarts on any drop, like the qualification count must
    always_ff @(posedge clk_sys or negedge reset_n)
        if (!reset_n) good_run <= '0;
        else if (!in_good || in_fault) good_run <= '0;
        else if (good_run != 16'hffff) good_run <= good_run + 16'd1;
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_unmapped;
        reg_rd && reg_addr > `ADDR_STATUS |=> reg_rdata == '0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
    property p_fault_off;
        in_fault [*4] |-> !input_pass_switch;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("pass on in fault");
    property p_qual_time;
        $rose(input_pass_switch) |-> good_run >= QUAL_MIN;
    endproperty
    a_qual_time: assert property (p_qual_time) else $error("early start");
    property p_hiz_off;
        reg_wr && reg_addr == `ADDR_CTRL && reg_wdata[`CTRL_HIZ] |=> ##[0:2] !input_pass_switch;
    endproperty
    a_hiz_off: assert property (p_hiz_off) else $error("hiz ignored");
    property p_inhibit;
        reg_wr && reg_addr == `ADDR_CTRL && reg_wdata[`CTRL_INHIBIT] |=> ##[0:2] !batt_charge_en;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit ignored");
    property p_supplement;
        supplement_mode |-> batt_switch_full_on && !batt_charge_en;
    endproperty
    a_supplement: assert property (p_supplement) else $error("supplement path");
    property p_no_input;
        !in_good [*4] |-> !input_pass_switch && batt_switch_full_on;
    endproperty
    a_no_input: assert property (p_no_input) else $error("battery not on");
    property p_sys_reg;
        (input_pass_switch && in_above_target) [*4] |-> sys_regulate;
    endproperty
    a_sys_reg: assert property (p_sys_reg) else $error("no regulation");
endmodule // charger_power_path_checker
bind charger_power_path_control charger_power_path_checker u_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_good(in_good),
    .in_fault(in_fault), .in_above_target(in_above_target),
    .input_pass_switch(input_pass_switch), .batt_charge_en(batt_charge_en),
    .batt_switch_full_on(batt_switch_full_on), .supplement_mode(supplement_mode),
    .sys_regulate(sys_regulate)
);
`default_nettype wire

/* dv/power_path_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charger_power_path_defs.vh"
// host side of the register port; never overlaps strobes
module power_path_host (
    // clock
    input  wire logic               clk_sys,
    // register port
    output var  logic [`ADDR_W-1:0] reg_addr,
    output var  logic [`DATA_W-1:0] reg_wdata,
    output var  logic               reg_wr,
    output var  logic               reg_rd,
    input  wire logic [`DATA_W-1:0] reg_rdata
);
    // idle bus from time zero
    initial begin
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // one-cycle write, changes just after an edge
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d; // stale data must not be relied on
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule // power_path_host
`default_nettype wire

/* dv/charger_power_path_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charger_power_path_defs.vh"
module charger_power_path_control_bench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [`ADDR_W-1:0] reg_addr;
    logic [`DATA_W-1:0] reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd;
    logic in_above_uvlo = 0, batt_above_uvlo = 0, in_good = 0, in_fault = 0;
    logic in_above_target = 0, input_limited = 0, sys_below_batt = 0;
    logic [3:0] die_over_thresh = 4'h0;
    wire logic [5:0] o; // outputs in status bit order
    int n_errors = 0, num_checks = 0;
    always #20 clk_sys = ~clk_sys;
    // short watchdogs so each code expires within a few thousand cycles
    charger_power_path_control #(.WDT_TICKS_1(25'd4), .WDT_TICKS_2(25'd8),
        .WDT_TICKS_163(25'd16)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_above_uvlo(in_above_uvlo), .batt_above_uvlo(batt_above_uvlo),
        .in_good(in_good), .in_fault(in_fault), .in_above_target(in_above_target),
        .input_limited(input_limited), .sys_below_batt(sys_below_batt),
        .die_over_thresh(die_over_thresh), .input_pass_switch(o[0]),
        .batt_charge_en(o[1]), .batt_switch_full_on(o[2]), .supplement_mode(o[3]),
        .charge_reduce(o[4]), .sys_regulate(o[5]));
    power_path_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // compare masked outputs once this edge has settled
    task automatic co(input logic [5:0] m, input logic [5:0] e);
        #1 chk({2'b00, o & m}, {2'b00, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bounded wait for the pass switch; running out is a mismatch
    task automatic wait_pass(input int lim);
        for (int i = 0; i < lim && o[0] !== 1'b1; i++) cyc(1);
        co(6'h01, 6'h01);
        if (o[0] !== 1'b1) wrap_up();
    endtask
    initial begin
        cyc(16);
        reset_n <= 1'b1;
        cyc(8);
        host.rd(`ADDR_CTRL, rv);
        chk(rv, `CTRL_RESET);
        co(6'h05, 6'h04);
        host.wr(`ADDR_CTRL, 8'h00); // both supplies low: dropped
        batt_above_uvlo <= 1'b1;
        cyc(8);
        host.rd(`ADDR_CTRL, rv);
        chk(rv, `CTRL_RESET);
        in_above_uvlo <= 1'b1;
        // every enabled watchdog code: holds just before expiry, reverts just after
        for (int k = 1; k < 4; k++) begin
            host.wr(`ADDR_CTRL, 8'(k * 16 + 12));
            cyc((4 << (k - 1)) * 200 - 300);
            host.rd(`ADDR_CTRL, rv);
            chk(rv, 8'(k * 16 + 12));
            cyc(600);
            host.rd(`ADDR_CTRL, rv);
            chk(rv, `CTRL_RESET);
            host.rd(`ADDR_STATUS, rv);
            chk(rv & 8'h40, 8'h40);
            host.rd(`ADDR_STATUS, rv);
            chk(rv & 8'h40, 8'h00);
        end
        // one-cycle drop mid-count must restart qualification
        in_good <= 1'b1;
        cyc(2000);
        host.rd(`ADDR_STATUS, rv);
        chk(rv & 8'h81, 8'h80);
        in_good <= 1'b0;
        cyc(1);
        in_good <= 1'b1;
        cyc(4700);
        co(6'h01, 6'h00);
        wait_pass(800);
        co(6'h03, 6'h03);
        in_above_target <= 1'b1;
        cyc(5);
        co(6'h20, 6'h20);
        in_above_target <= 1'b0;
        cyc(5);
        co(6'h21, 6'h01);
        host.wr(`ADDR_CTRL, 8'h0e);
        cyc(4);
        co(6'h03, 6'h01);
        // each thermal select picks its own comparator
        for (int s = 0; s < 4; s++) begin
            host.wr(`ADDR_CTRL, 8'(s * 4));
            die_over_thresh <= 4'(1 << s);
            cyc(5);
            co(6'h10, 6'h10);
            die_over_thresh <= ~4'(1 << s);
            cyc(5);
            co(6'h10, 6'h00);
        end
        die_over_thresh <= 4'h0;
        input_limited <= 1'b1;
        cyc(5);
        co(6'h10, 6'h10);
        input_limited <= 1'b0;
        sys_below_batt <= 1'b1;
        cyc(5);
        co(6'h0f, 6'h0d);
        sys_below_batt <= 1'b0;
        cyc(5);
        co(6'h08, 6'h00);
        host.wr(`ADDR_CTRL, 8'h0d);
        cyc(4);
        co(6'h01, 6'h00);
        host.wr(`ADDR_CTRL, 8'h0c);
        wait_pass(6000);
        in_fault <= 1'b1;
        cyc(4);
        co(6'h01, 6'h00);
        in_fault <= 1'b0;
        in_good <= 1'b0;
        cyc(5);
        co(6'h05, 6'h04);
        // unmapped and read-only places
        host.rd(4'h5, rv);
        chk(rv, 8'h00);
        host.wr(4'h5, 8'hff);
        host.wr(`ADDR_STATUS, 8'hff);
        host.rd(`ADDR_CTRL, rv);
        chk(rv, `CTRL_RESET);
        host.wr(`ADDR_CTRL, 8'hff);
        host.rd(`ADDR_CTRL, rv);
        chk(rv, 8'h3f);
        wrap_up();
    end
endmodule // charger_power_path_control_bench
`default_nettype wire
